/* src/mmdia_pkg.sv */
package mmdia_pkg;

	localparam logic [4:0] MMDIA_CTRL_ADDR = 5'h0D;
	localparam logic [4:0] MMDIA_DATA_ADDR = 5'h0E;

	localparam logic [4:0] MMDIA_SPACE_VENDOR = 5'h1F;
	localparam logic [4:0] MMDIA_SPACE_PMA = 5'h01;

	localparam int MMDIA_FUNC_MSB = 15;
	localparam int MMDIA_FUNC_LSB = 14;
	localparam int MMDIA_SPACE_MSB = 4;

	localparam logic [15:0] MMDIA_WORD_ZERO = 16'h0000;
	localparam logic [15:0] MMDIA_ADDR_STEP = 16'h0001;
	localparam logic [4:0] MMDIA_SPACE_RST = 5'h00;
	localparam int MMDIA_DEPTH_DEFAULT = 32;

	typedef enum logic [1:0] {
		MMDIA_FN_ADDR = 2'b00,
		MMDIA_FN_NOINC = 2'b01,
		MMDIA_FN_INC_RW = 2'b10,
		MMDIA_FN_INC_WR = 2'b11
	} mmdia_func_t;

endpackage

/* src/mmdia_ext_mem.sv */
`timescale 1ns/1ps

module mmdia_ext_mem #(
	parameter int DW = 16,
	parameter int DEPTH = 64
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic wr_en, // write strobe
	input wire logic [$clog2(DEPTH)-1:0] wr_addr, // write index
	input wire logic [DW-1:0] wr_data, // write word
	input wire logic rd_en, // read strobe
	input wire logic [$clog2(DEPTH)-1:0] rd_addr, // read index
	output logic [DW-1:0] rd_data // registered read word
);
	logic [DW-1:0] mem [DEPTH];

	generate
		if (DW < 1 || DEPTH < 2) begin : g_bad_param
			$error("DW must be positive and DEPTH at least 2");
		end
	endgenerate

	// array left unreset so it maps onto plain storage
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

/* src/mmdia_indirect_access.sv */
//Contract
// (RULE1) Control value 0x1F picks the address function for the vendor space, so the next data-register write loads its address.
// (RULE2) Control value 0x1 picks the address function for the PMA space, so the next data-register write loads its address.
// (RULE3) Control value 0x801F makes data-register accesses reach the vendor register and bumps the address after reads and writes.
// (RULE4) Control value 0xC01F makes data-register accesses reach the vendor register and bumps the address after writes.
// (RULE5) For the PMA space 0x8001 bumps after reads and writes and 0xC001 bumps after writes only.
// (RULE6) Control value 0x4001 reaches the addressed PMA register and leaves the address as it is.
// (RULE7) In a bumping mode each further write lands on the next higher extended address.
// (RULE8) With function 10 successive reads return consecutive extended registers.
// (RULE9) The manager writes a register by setting address function, address, data function, then writing data.
// (RULE10) The manager reads a register by setting address function, address, data function, then reading data.
// (RULE11) With function 11 a read returns the addressed register and leaves the address unchanged.
// (RULE12) Data-register accesses under a space code other than vendor or PMA are ignored.
// (RULE13) Control sits at direct address 0xD, address/data at 0xE, space code in bits 4:0, function in 15:14.
`timescale 1ns/1ps

module mmdia_indirect_access #(
	parameter int DEPTH = mmdia_pkg::MMDIA_DEPTH_DEFAULT
) (
	input wire logic clk, // 20 MHz system clock
	input wire logic nrst, // async reset, active low
	input wire logic acc_valid, // one-cycle direct access request
	input wire logic acc_write, // 1 write, 0 read
	input wire logic [4:0] acc_addr, // direct register address
	input wire logic [15:0] acc_wdata, // write word
	output logic [15:0] acc_rdata, // read word, valid with acc_rvalid
	output logic acc_rvalid, // one-cycle read answer
	output logic acc_hit, // answer came from 0xD or 0xE
	output mmdia_pkg::mmdia_func_t access_function, // current function code
	output logic [4:0] target_space_code, // current space code
	output logic [15:0] vendor_address, // vendor space address register
	output logic [15:0] pma_address // pma_register_space address register
);
	import mmdia_pkg::*;

	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || DEPTH > 65536 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("DEPTH must be a power of two from 2 to 65536");
		end
	endgenerate

	generate
		if (MMDIA_FUNC_MSB != MMDIA_FUNC_LSB + 1 || MMDIA_FUNC_MSB > 15) begin : g_bad_field
			$error("function field must be two adjacent bits of the control word");
		end
	endgenerate

	// where a pending read answer comes from
	typedef enum logic [1:0] {
		MMDIA_SRC_ZERO = 2'b00,
		MMDIA_SRC_CTRL = 2'b01,
		MMDIA_SRC_ADDR = 2'b10,
		MMDIA_SRC_MEM = 2'b11
	} mmdia_src_t;

	// one address register per space so switching spaces keeps both
	localparam int N_SPACE = 2;
	localparam logic [4:0] SPACE_CODE [N_SPACE] = '{MMDIA_SPACE_VENDOR, MMDIA_SPACE_PMA};

	logic ctrl_sel;
	logic data_sel;
	logic space_ok;
	logic sel_pma;
	logic [15:0] cur_addr;
	logic in_range;
	logic fn_data;
	logic fn_step;
	logic data_acc;
	logic bump;
	logic mem_wr;
	logic mem_rd;
	logic [AW:0] mem_idx;
	logic [15:0] mem_rdata;
	logic [15:0] ctrl_word;
	logic [15:0] space_addr [N_SPACE];
	mmdia_src_t rd_src;
	mmdia_src_t rd_src_q;
	logic rd_pend;
	logic rd_hit;
	logic [15:0] rd_word;

	assign ctrl_sel = acc_valid && acc_addr == MMDIA_CTRL_ADDR; // RULE13
	assign data_sel = acc_valid && acc_addr == MMDIA_DATA_ADDR; // RULE13
	assign space_ok = target_space_code == MMDIA_SPACE_VENDOR
		|| target_space_code == MMDIA_SPACE_PMA; // RULE12
	assign sel_pma = target_space_code == MMDIA_SPACE_PMA;
	assign cur_addr = sel_pma ? pma_address : vendor_address;
	// addresses past the implemented depth read zero and drop writes
	assign in_range = (cur_addr >> AW) == MMDIA_WORD_ZERO;
	// which functions reach the array and which move the address afterwards
	always_comb begin
		fn_data = 1'b1;
		fn_step = 1'b0;
		unique case (access_function)
			MMDIA_FN_ADDR: begin
				fn_data = 1'b0; // RULE1 RULE2
			end
			MMDIA_FN_NOINC: begin
				fn_step = 1'b0; // RULE6
			end
			MMDIA_FN_INC_RW: begin
				fn_step = 1'b1; // RULE3 RULE5 RULE8
			end
			MMDIA_FN_INC_WR: begin
				// writes only, so a read here keeps the address
				fn_step = acc_write; // RULE4 RULE5 RULE11
			end
		endcase
	end
	assign data_acc = data_sel && space_ok && fn_data; // RULE12
	assign bump = data_acc && fn_step; // RULE7
	assign mem_wr = data_acc && acc_write && in_range; // RULE6
	assign mem_rd = data_acc && !acc_write; // RULE6
	assign mem_idx = {sel_pma, cur_addr[AW-1:0]};
	assign ctrl_word = {access_function, 9'h000, target_space_code};

	// control register: function and space code kept, reserved bits read zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			access_function <= MMDIA_FN_ADDR;
			target_space_code <= MMDIA_SPACE_RST;
		end else if (ctrl_sel && acc_write) begin
			access_function <= mmdia_func_t'(acc_wdata[MMDIA_FUNC_MSB:MMDIA_FUNC_LSB]); // RULE13
			target_space_code <= acc_wdata[MMDIA_SPACE_MSB:0]; // RULE13
		end
	end

	// address increments wrap at the top of the 16-bit space
	generate
		for (genvar k = 0; k < N_SPACE; k++) begin : g_space
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					space_addr[k] <= MMDIA_WORD_ZERO;
				end else if (data_sel && target_space_code == SPACE_CODE[k]) begin
					if (!fn_data && acc_write) begin
						space_addr[k] <= acc_wdata; // RULE1 RULE2
					end else if (bump) begin
						space_addr[k] <= space_addr[k] + MMDIA_ADDR_STEP; // RULE3 RULE4 RULE5 RULE7 RULE8
					end
				end
			end
		end
	endgenerate
	assign vendor_address = space_addr[0];
	assign pma_address = space_addr[1];

	mmdia_ext_mem #(
		.DW(16),
		.DEPTH(2 * DEPTH)
	) u_mem (
		.clk(clk),
		.nrst(nrst),
		.wr_en(mem_wr),
		.wr_addr(mem_idx),
		.wr_data(acc_wdata),
		.rd_en(mem_rd),
		.rd_addr(mem_idx),
		.rd_data(mem_rdata)
	);

	// out-of-range and foreign-space reads fall through to zero
	always_comb begin
		rd_src = MMDIA_SRC_ZERO;
		if (ctrl_sel) begin
			rd_src = MMDIA_SRC_CTRL;
		end else if (data_sel && space_ok && !fn_data) begin
			rd_src = MMDIA_SRC_ADDR;
		end else if (mem_rd && in_range) begin
			rd_src = MMDIA_SRC_MEM; // RULE6
		end
	end

	// first read stage: choose the source while memory fetches
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_pend <= 1'b0;
			rd_src_q <= MMDIA_SRC_ZERO;
			rd_hit <= 1'b0;
			rd_word <= MMDIA_WORD_ZERO;
		end else begin
			rd_pend <= acc_valid && !acc_write;
			rd_src_q <= rd_src;
			rd_hit <= ctrl_sel || data_sel;
			unique case (rd_src)
				MMDIA_SRC_CTRL: begin
					rd_word <= ctrl_word; // RULE13
				end
				MMDIA_SRC_ADDR: begin
					rd_word <= cur_addr; // RULE1 RULE2
				end
				MMDIA_SRC_ZERO, MMDIA_SRC_MEM: begin
					rd_word <= MMDIA_WORD_ZERO;
				end
			endcase
		end
	end

	// uniform two-cycle read latency whatever the source
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_rvalid <= 1'b0;
			acc_hit <= 1'b0;
			acc_rdata <= MMDIA_WORD_ZERO;
		end else begin
			acc_rvalid <= rd_pend;
			acc_hit <= rd_pend && rd_hit;
			if (rd_pend) begin
				unique case (rd_src_q)
					MMDIA_SRC_CTRL, MMDIA_SRC_ADDR: begin
						acc_rdata <= rd_word;
					end
					MMDIA_SRC_MEM: begin
						acc_rdata <= mem_rdata; // RULE8 RULE11
					end
					MMDIA_SRC_ZERO: begin
						acc_rdata <= MMDIA_WORD_ZERO; // RULE12
					end
				endcase
			end
		end
	end
endmodule

/* test/mmdia_chk.sv */
`timescale 1ns/1ps
module mmdia_chk (
	input wire logic clk, // clock
	input wire logic nrst, // reset
	input wire logic acc_valid, // request
	input wire logic acc_write, // write
	input wire logic [4:0] acc_addr, // address
	input wire logic [15:0] acc_wdata, // word
	input wire logic acc_rvalid, // answer
	input wire mmdia_pkg::mmdia_func_t access_function, // function
	input wire logic [4:0] target_space_code, // space
	input wire logic [15:0] vendor_address, // vendor
	input wire logic [15:0] pma_address // pma
);
	import mmdia_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic dat = acc_valid && acc_addr == MMDIA_DATA_ADDR;
	wire logic vsp = target_space_code == MMDIA_SPACE_VENDOR;
	wire logic ok = vsp || target_space_code == MMDIA_SPACE_PMA;
	// one view of whichever address register the space code selects
	wire logic [15:0] sel = vsp ? vendor_address : pma_address;
	sequence s_read; acc_valid && !acc_write; endsequence
	property p_answer; s_read |-> ##2 acc_rvalid; endproperty
	a_answer: assert property (p_answer) else $error("read not answered");
	property p_lone; acc_rvalid |-> $past(acc_valid && !acc_write, 2); endproperty
	a_lone: assert property (p_lone) else $error("stray answer");
	property p_ctrl; acc_valid && acc_write && acc_addr == MMDIA_CTRL_ADDR |=>
		{access_function, target_space_code} == {$past(acc_wdata[15:14]), $past(acc_wdata[4:0])};
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control not stored");
	property p_load; dat && acc_write && ok && access_function == MMDIA_FN_ADDR |=>
		sel == $past(acc_wdata); endproperty
	a_load: assert property (p_load) else $error("address not loaded");
	property p_bump; dat && ok && (access_function == MMDIA_FN_INC_RW ||
		access_function == MMDIA_FN_INC_WR && acc_write) |=> sel == $past(sel) + 16'h0001;
	endproperty
	a_bump: assert property (p_bump) else $error("no bump");
	property p_rdhold; dat && !acc_write && access_function == MMDIA_FN_INC_WR |=> $stable(sel);
	endproperty
	a_rdhold: assert property (p_rdhold) else $error("read bumped");
	property p_noinc; dat && access_function == MMDIA_FN_NOINC |=> $stable(sel); endproperty
	a_noinc: assert property (p_noinc) else $error("address moved");
	property p_ignore; dat && !ok |=> $stable(vendor_address) && $stable(pma_address);
	endproperty
	a_ignore: assert property (p_ignore) else $error("bad space used");
endmodule
bind mmdia_indirect_access mmdia_chk i_mmdia_chk (.clk, .nrst, .acc_valid, .acc_write,
	.acc_addr, .acc_wdata, .acc_rvalid, .access_function, .target_space_code,
	.vendor_address, .pma_address);

/* test/mmdia_mgr.sv */
`timescale 1ns/1ps
module mmdia_mgr (
	input wire logic clk, // clock
	input wire logic [15:0] acc_rdata, // read word
	input wire logic acc_rvalid, // answer
	output logic acc_valid, // request
	output logic acc_write, // write
	output logic [4:0] acc_addr, // address
	output logic [15:0] acc_wdata // word
);
	import mmdia_pkg::*;
	initial begin
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_addr = 5'h00;
		acc_wdata = 16'h0000;
	end
	task automatic put(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(negedge clk);
		acc_valid = 1'b1;
		acc_write = w;
		acc_addr = a;
		acc_wdata = d;
		@(negedge clk);
		acc_valid = 1'b0;
		// scrambled once released so a stale word never looks live
		acc_wdata = ~d;
	endtask
	// answers that never came; the bench adds them to its mismatches
	int misses = 0;
	task automatic get(input logic [4:0] a, output logic [15:0] d);
		bit seen;
		d = 16'hXXXX;
		seen = 1'b0;
		put(1'b0, a, 16'h0000);
		repeat (3) begin
			@(negedge clk);
			if (acc_rvalid === 1'b1) begin
				d = acc_rdata;
				seen = 1'b1;
				break;
			end
		end
		if (!seen) begin
			misses++;
		end
	endtask
	task automatic setup(input logic [4:0] sp, input logic [15:0] a, input logic [1:0] f);
		put(1'b1, MMDIA_CTRL_ADDR, {11'h000, sp});
		put(1'b1, MMDIA_DATA_ADDR, a);
		put(1'b1, MMDIA_CTRL_ADDR, {f, 9'h000, sp});
	endtask
endmodule

/* test/mmd_indirect_register_access_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module mmd_indirect_register_access_bench;
	import mmdia_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	int n_errors = 0;
	int checks_done = 0;
	logic [15:0] rd;
	wire logic acc_valid, acc_write, acc_rvalid, acc_hit;
	wire logic [4:0] acc_addr, target_space_code;
	wire logic [15:0] acc_wdata, acc_rdata, vendor_address, pma_address;
	wire mmdia_func_t access_function;
	always #25 clk = ~clk;
	mmdia_indirect_access #(.DEPTH(4)) i_mmdia_indirect_access (.clk, .nrst, .acc_valid,
		.acc_write, .acc_addr, .acc_wdata, .acc_rdata, .acc_rvalid, .acc_hit,
		.access_function, .target_space_code, .vendor_address, .pma_address);
	mmdia_mgr i_mmdia_mgr (.clk, .acc_rdata, .acc_rvalid, .acc_valid, .acc_write,
		.acc_addr, .acc_wdata);
	task automatic give_verdict();
		n_errors = n_errors + i_mmdia_mgr.misses;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic t_vendor();
		i_mmdia_mgr.put(1'b1, MMDIA_CTRL_ADDR, 16'hFFFF);
		i_mmdia_mgr.get(MMDIA_CTRL_ADDR, rd);
		`CHK("ctrl", 16'hC01F, rd)
		`CHK("hit", 1'b1, acc_hit)
		i_mmdia_mgr.get(5'h00, rd);
		`CHK("other", 16'h0000, rd)
		`CHK("nohit", 1'b0, acc_hit)
		i_mmdia_mgr.setup(MMDIA_SPACE_VENDOR, 16'h0002, MMDIA_FN_INC_WR);
		i_mmdia_mgr.put(1'b1, MMDIA_DATA_ADDR, 16'hA5A5);
		i_mmdia_mgr.put(1'b1, MMDIA_DATA_ADDR, 16'h5A5A);
		i_mmdia_mgr.get(MMDIA_DATA_ADDR, rd);
		`CHK("oor", 16'h0000, rd)
		`CHK("vaddr", 16'h0004, vendor_address)
		i_mmdia_mgr.setup(MMDIA_SPACE_VENDOR, 16'h0002, MMDIA_FN_INC_RW);
		i_mmdia_mgr.get(MMDIA_DATA_ADDR, rd);
		`CHK("rd0", 16'hA5A5, rd)
		i_mmdia_mgr.get(MMDIA_DATA_ADDR, rd);
		`CHK("rd1", 16'h5A5A, rd)
		i_mmdia_mgr.put(1'b1, MMDIA_CTRL_ADDR, 16'h001F);
		i_mmdia_mgr.get(MMDIA_DATA_ADDR, rd);
		`CHK("vaddr", 16'h0004, rd)
	endtask
	task automatic t_pma();
		i_mmdia_mgr.setup(MMDIA_SPACE_PMA, 16'h0001, MMDIA_FN_INC_WR);
		i_mmdia_mgr.put(1'b1, MMDIA_DATA_ADDR, 16'h1234);
		i_mmdia_mgr.setup(MMDIA_SPACE_PMA, 16'h0001, MMDIA_FN_NOINC);
		i_mmdia_mgr.get(MMDIA_DATA_ADDR, rd);
		`CHK("pma", 16'h1234, rd)
		`CHK("paddr", 16'h0001, pma_address)
		i_mmdia_mgr.put(1'b1, MMDIA_CTRL_ADDR, 16'h4002);
		i_mmdia_mgr.put(1'b1, MMDIA_DATA_ADDR, 16'hBEEF);
		i_mmdia_mgr.get(MMDIA_DATA_ADDR, rd);
		`CHK("bad", 16'h0000, rd)
		`CHK("badhit", 1'b1, acc_hit)
		`CHK("paddr", 16'h0001, pma_address)
		i_mmdia_mgr.setup(MMDIA_SPACE_PMA, 16'h0001, MMDIA_FN_INC_RW);
		i_mmdia_mgr.get(MMDIA_DATA_ADDR, rd);
		`CHK("pma1", 16'h1234, rd)
		`CHK("paddr", 16'h0002, pma_address)
	endtask
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		t_vendor();
		t_pma();
		give_verdict();
	end
	initial begin
		#200us;
		n_errors++;
		give_verdict();
	end
endmodule
